// ==== hdl/hbd_dma_interface.sv ====
// Host bus side of the SCSI processor: DMA master sequencing, slave register cycles,
// residual status and endian lane mapping.
// Assumes a single clk_sys domain and inputs synchronous to it.
//
// Notes on behaviour
// - Status one bit 6: output latch full.
// - Status one bit 5: holding reg full, sync send.
// - Status one bit 7: input latch full, async receive.
// - Status two bits 7-4: sync receive FIFO count.
// - Endian never moves FIFO or register lanes.
// - Big endian: control zero at byte 03h.
// - Little endian: control zero at byte 00h.
// - Stream bytes map to ascending memory addresses.
// - Internal register index is always little endian.
// - Never a three byte host transfer.
// - Cache mode: byte, word, longwords to align.
// - Aligned: four longword bursts while count exceeds 31.
// - Tail: longwords, then word for 3/2, byte for 1.
// - Otherwise 1, 2, 4 or 8 transfers per tenure.
// - Never exceed burst length; short final tenure.
// - New arbitration per tenure, 5-8 clock gap.
// - Retry signal pair reruns same address and size.
// - Cache burst retry only first beat, else error.
// - Slave ready, then sample termination each edge.
// - Ack enable drives termination pin in slave mode.
`include "hbd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module hbd_dma_interface #(
  parameter int COUNT_W = 24
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Mode straps
  input wire logic bigEndian,
  input wire logic busModeSync,
  input wire logic internalAckEnable,
  // DMA command
  input wire logic dmaStart,
  input wire logic dmaToMem,
  input wire logic cacheMode,
  input wire logic [1:0] burstSel,
  input wire logic [31:0] startAddr,
  input wire logic [COUNT_W-1:0] byteCount,
  output logic dmaBusy,
  output logic dmaDone,
  output logic dmaError,
  // Host bus master
  output logic busRequest,
  input wire logic busGrant,
  output logic masterStrobe,
  output logic masterWrite,
  output logic [31:0] masterAddr,
  output logic [1:0] masterSize,
  output logic [3:0] masterByteEn,
  output logic [31:0] masterWdata,
  input wire logic [31:0] masterRdata,
  output logic cacheBurstRequest,
  input wire logic transferAckN,
  input wire logic transferErrorAckN,
  input wire logic haltN,
  input wire logic busFaultN,
  // Data from the DMA FIFO toward memory
  input wire logic [31:0] inData,
  input wire logic inValid,
  output logic inReady,
  // Data from memory toward the DMA FIFO
  output logic [31:0] outData,
  output logic [3:0] outLanes,
  output logic outValid,
  input wire logic outReady,
  // Host bus slave
  input wire logic chipSelectN,
  input wire logic slaveWrite,
  input wire logic [1:0] slaveAddr,
  input wire logic [1:0] slaveSize,
  input wire logic [31:0] slaveWdata,
  output logic [31:0] slaveRdata,
  output logic slaveReadyOut,
  input wire logic cycleTerminateNIn,
  output logic cycleTerminateNOut,
  output logic cycleTerminateOe,
  // SCSI data path residue
  input wire logic outLatchFull,
  input wire logic outHoldFull,
  input wire logic inLatchFull,
  input wire logic syncMode,
  input wire logic [3:0] rxFifoCount,
  output logic [7:0] scsiStatusOne,
  output logic [7:0] scsiStatusTwo
);

  hbd_pkg::hbd_state_s cur_r;
  hbd_pkg::hbd_state_s cur_nxt;

  // Lanes touched by an access; big endian mirrors the lane number.
  function automatic logic [3:0] laneMask(input logic [1:0] a, input hbd_pkg::hbd_size_e sz,
                                          input logic big);
    logic [1:0] ln;
    ln = big ? ~a : a;
    if (sz == hbd_pkg::HBD_SZ_LONG) begin
      laneMask = 4'hF;
    end else if (sz == hbd_pkg::HBD_SZ_WORD) begin
      laneMask = ln[1] ? 4'hC : 4'h3;
    end else begin
      laneMask = 4'h1 << ln;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer sizing.

  logic retry;
  logic fault;
  logic acked;
  hbd_pkg::hbd_size_e nextSize;
  logic [23:0] nextBytes;
  logic [23:0] remAfter;
  logic canIssue;

  assign retry = busModeSync ? (!transferAckN && !transferErrorAckN)
                             : (!haltN && !busFaultN);
  assign fault = !retry && (busModeSync ? !transferErrorAckN : !busFaultN);
  assign acked = !retry && !fault && !transferAckN;

  always_comb begin
    // The size is picked from the address and count only; three bytes never go out.
    if (cur_r.addr[0] || cur_r.rem == 24'h000001) begin
      nextSize = hbd_pkg::HBD_SZ_BYTE;
      nextBytes = 24'h000001;
    end else if (cur_r.addr[1] || cur_r.rem < 24'h000004) begin
      nextSize = hbd_pkg::HBD_SZ_WORD;
      nextBytes = 24'h000002;
    end else begin
      nextSize = hbd_pkg::HBD_SZ_LONG;
      nextBytes = 24'h000004;
    end
  end

  assign remAfter = cur_r.rem - nextBytes;
  // A read waits for buffer room and a write for a word from the FIFO, so a stall loses nothing.
  assign canIssue = cur_r.write ? (inValid && !cur_r.inReady) : (cur_r.bufCnt != 2'h2);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic [3:0] slvMask;
    logic termSeen;
    logic pop;
    slvMask = 4'h0;
    termSeen = 1'b0;
    pop = 1'b0;
    cur_nxt = cur_r;
    cur_nxt.done = 1'b0;
    cur_nxt.inReady = 1'b0;

    // Residue of the SCSI data path, sampled every clock.
    cur_nxt.status1 = 8'h00;
    cur_nxt.status1[`HBD_SR1_OUT_LATCH] = outLatchFull;
    cur_nxt.status1[`HBD_SR1_OUT_HOLD] = outHoldFull && syncMode && !dmaToMem;
    cur_nxt.status1[`HBD_SR1_IN_LATCH] = inLatchFull && !syncMode && dmaToMem;
    cur_nxt.status2 = 8'h00;
    cur_nxt.status2[`HBD_SR2_CNT_MSB:`HBD_SR2_CNT_LSB] =
      (syncMode && dmaToMem) ? rxFifoCount : 4'h0;

    // Two-entry output buffer; the head always sits in slot 0.
    if (cur_r.bufCnt != 2'h0 && outReady) begin
      pop = 1'b1;
      cur_nxt.bufData[0] = cur_r.bufData[1];
      cur_nxt.bufLane[0] = cur_r.bufLane[1];
      cur_nxt.bufCnt = cur_r.bufCnt - 2'h1;
    end

    case (cur_r.st)
      hbd_pkg::HBD_IDLE: begin
        if (dmaStart && byteCount != '0) begin
          cur_nxt.addr = startAddr;
          cur_nxt.rem = 24'(byteCount);
          cur_nxt.write = dmaToMem;
          cur_nxt.busy = 1'b1;
          cur_nxt.err = 1'b0;
          cur_nxt.busReq = 1'b1;
          cur_nxt.st = hbd_pkg::HBD_REQ;
        end
      end
      hbd_pkg::HBD_REQ: begin
        if (busGrant) begin
          cur_nxt.beats = 5'h00;
          cur_nxt.cacheTen = 1'b0;
          cur_nxt.st = hbd_pkg::HBD_XFER;
          if (!cacheMode) begin
            cur_nxt.limit = 5'h01 << burstSel;
          end else if (cur_r.rem < `HBD_LINE_MIN) begin
            cur_nxt.limit = `HBD_NO_LIMIT;
          end else if (cur_r.addr[3:0] != 4'h0) begin
            cur_nxt.limit = `HBD_ONE_BEAT;
          end else begin
            cur_nxt.limit = `HBD_CACHE_BEATS;
            cur_nxt.cacheTen = 1'b1;
            cur_nxt.cache_burst_request = 1'b1;
          end
        end
      end
      hbd_pkg::HBD_XFER: begin
        if (!cur_r.strobe) begin
          if (canIssue) begin
            cur_nxt.strobe = 1'b1;
            cur_nxt.mAddr = cur_r.addr;
            cur_nxt.mSize = nextSize;
            // Lanes follow the low address bits; FIFO data lanes stay put.
            cur_nxt.mBe = laneMask(cur_r.addr[1:0], nextSize, bigEndian);
          end
        end else if (retry) begin
          cur_nxt.strobe = 1'b0;
          if (cur_r.cacheTen && cur_r.beats != 5'h00) begin
            cur_nxt.err = 1'b1;
            cur_nxt.rem = 24'h000000;
            cur_nxt.busReq = 1'b0;
            cur_nxt.cache_burst_request = 1'b0;
            cur_nxt.st = hbd_pkg::HBD_GAP;
            cur_nxt.gap = `HBD_FAIR_GAP;
          end
        end else if (fault) begin
          cur_nxt.strobe = 1'b0;
          cur_nxt.err = 1'b1;
          cur_nxt.rem = 24'h000000;
          cur_nxt.busReq = 1'b0;
          cur_nxt.cache_burst_request = 1'b0;
          cur_nxt.st = hbd_pkg::HBD_GAP;
          cur_nxt.gap = `HBD_FAIR_GAP;
        end else if (acked) begin
          cur_nxt.strobe = 1'b0;
          cur_nxt.addr = cur_r.addr + 32'(nextBytes);
          cur_nxt.rem = remAfter;
          cur_nxt.beats = cur_r.beats + 5'h01;
          if (cur_r.write) begin
            cur_nxt.inReady = 1'b1;
          end else begin
            cur_nxt.bufData[cur_nxt.bufCnt] = masterRdata;
            cur_nxt.bufLane[cur_nxt.bufCnt] = cur_r.mBe;
            cur_nxt.bufCnt = cur_nxt.bufCnt + 2'h1;
          end
          if (cur_r.beats + 5'h01 == cur_r.limit || remAfter == 24'h000000) begin
            cur_nxt.busReq = 1'b0;
            cur_nxt.cache_burst_request = 1'b0;
            cur_nxt.st = hbd_pkg::HBD_GAP;
            cur_nxt.gap = `HBD_FAIR_GAP;
          end
        end
      end
      hbd_pkg::HBD_GAP: begin
        cur_nxt.gap = cur_r.gap - 4'h1;
        if (cur_r.gap == 4'h1) begin
          if (cur_r.rem == 24'h000000) begin
            cur_nxt.busy = 1'b0;
            cur_nxt.done = 1'b1;
            cur_nxt.st = hbd_pkg::HBD_IDLE;
          end else begin
            cur_nxt.busReq = 1'b1;
            cur_nxt.st = hbd_pkg::HBD_REQ;
          end
        end
      end
      default: begin
        cur_nxt.st = hbd_pkg::HBD_IDLE;
      end
    endcase
    if (pop && cur_nxt.bufCnt == 2'h0) begin
      cur_nxt.bufCnt = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Slave register cycle.
    slvMask = laneMask(slaveAddr, hbd_pkg::hbd_size_e'(slaveSize), bigEndian);
    termSeen = internalAckEnable ? cur_r.ready : !cycleTerminateNIn;
    if (!cur_r.sAct) begin
      if (!chipSelectN) begin
        cur_nxt.sAct = 1'b1;
        cur_nxt.sPh = 2'h1;
      end
    end else if (!cur_r.ready) begin
      cur_nxt.sPh = cur_r.sPh + 2'h1;
      // Write data is only trusted from the second clock after select.
      if (cur_r.sPh == `HBD_WDATA_DLY) begin
        // Register i always lives on lane i, whatever the endian setting.
        for (int i = 0; i < 4; i++) begin
          if (slvMask[i] && slaveWrite) begin
            cur_nxt.regs[i] = slaveWdata[8*i +: 8];
          end
        end
        cur_nxt.rdata = cur_r.regs;
        cur_nxt.ready = 1'b1;
        cur_nxt.termOe = internalAckEnable;
        cur_nxt.termOut = !internalAckEnable;
      end
    end else if (termSeen) begin
      cur_nxt.ready = 1'b0;
      cur_nxt.sAct = 1'b0;
      cur_nxt.termOe = 1'b0;
      cur_nxt.termOut = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur_r <= '0;
      cur_r.st <= hbd_pkg::HBD_IDLE;
      cur_r.termOut <= 1'b1;
      cur_r.regs <= {4{`HBD_REG_RST}};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from the state register except masterWdata, which is inData.

  assign dmaBusy = cur_r.busy;
  assign dmaDone = cur_r.done;
  assign dmaError = cur_r.err;
  assign busRequest = cur_r.busReq;
  assign masterStrobe = cur_r.strobe;
  assign masterWrite = cur_r.write;
  assign masterAddr = cur_r.mAddr;
  assign masterSize = cur_r.mSize;
  assign masterByteEn = cur_r.mBe;
  assign masterWdata = inData;
  assign cacheBurstRequest = cur_r.cache_burst_request;
  assign inReady = cur_r.inReady;
  assign outData = cur_r.bufData[0];
  assign outLanes = cur_r.bufLane[0];
  assign outValid = cur_r.bufCnt != 2'h0;
  assign slaveRdata = cur_r.rdata;
  assign slaveReadyOut = cur_r.ready;
  assign cycleTerminateNOut = cur_r.termOut;
  assign cycleTerminateOe = cur_r.termOe;
  assign scsiStatusOne = cur_r.status1;
  assign scsiStatusTwo = cur_r.status2;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence sTenureEnd;
    $fell(cur_r.busReq);
  endsequence
  sequence sQuietGap;
    !cur_r.busReq [*5];
  endsequence

  AST_FAIR_GAP: assert property (@(posedge clk_sys) disable iff (!nrst)
    sTenureEnd |-> sQuietGap)
    else $error("Bus re-requested inside the fairness gap.");
  AST_NO_THREE: assert property (@(posedge clk_sys) disable iff (!nrst)
    cur_r.strobe |-> $countones(cur_r.mBe) != 3)
    else $error("Three byte transfer issued.");
  AST_BURST_LEN: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cur_r.strobe && !cacheMode) |-> cur_r.beats < (5'h01 << burstSel))
    else $error("Programmed burst length exceeded.");
  AST_CACHE_LONG: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cur_r.strobe && cur_r.cache_burst_request) |-> cur_r.mSize == hbd_pkg::HBD_SZ_LONG
      && cur_r.mAddr[1:0] == 2'h0)
    else $error("Cache burst beat is not an aligned longword.");
  AST_RETRY_SAME: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cur_r.strobe && retry && !cur_r.cacheTen) |=> !cur_r.strobe && $stable(cur_r.mAddr)
      && cur_r.st == hbd_pkg::HBD_XFER)
    else $error("Retry did not rerun the same cycle.");
  AST_LATE_RETRY: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cur_r.strobe && retry && cur_r.cacheTen && cur_r.beats != 5'h00) |=> cur_r.err)
    else $error("Late cache burst retry did not flag an error.");
  AST_STATUS_ONE: assert property (@(posedge clk_sys) disable iff (!nrst)
    ##1 scsiStatusOne[`HBD_SR1_OUT_LATCH] == $past(outLatchFull))
    else $error("Output latch flag does not follow the latch.");
  AST_STATUS_TWO: assert property (@(posedge clk_sys) disable iff (!nrst)
    (syncMode && dmaToMem) |=> scsiStatusTwo[`HBD_SR2_CNT_MSB:`HBD_SR2_CNT_LSB]
      == $past(rxFifoCount))
    else $error("Receive FIFO count not reported.");
  AST_TERM_END: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cur_r.ready && !internalAckEnable && !cycleTerminateNIn) |=> !cur_r.ready)
    else $error("Slave cycle not ended on termination.");
  AST_EA_DRIVE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cur_r.ready && cur_r.termOe) |-> !cur_r.termOut)
    else $error("Termination pin driven inactive while ready.");

endmodule
`default_nettype wire

// ==== hdl/hbd_regs.svh ====
// Offsets, field positions, reset values and timing counts of the host bus DMA block.
// Assumes it is included by bare name from files under hdl/.
`ifndef HBD_REGS_SVH
`define HBD_REGS_SVH
`define HBD_IDX_CTRL0 2'h0
`define HBD_IDX_CTRL1 2'h1
`define HBD_IDX_DEST 2'h2
`define HBD_IDX_IEN 2'h3
`define HBD_REG_RST 8'h00
`define HBD_SR1_IN_LATCH 7
`define HBD_SR1_OUT_LATCH 6
`define HBD_SR1_OUT_HOLD 5
`define HBD_SR2_CNT_LSB 4
`define HBD_SR2_CNT_MSB 7
`define HBD_FAIR_GAP 4'h5
`define HBD_CACHE_BEATS 5'h04
`define HBD_ONE_BEAT 5'h01
`define HBD_NO_LIMIT 5'h1F
`define HBD_LINE_MIN 24'h000020
`define HBD_WDATA_DLY 2'h2
`endif

// ==== hdl/hbd_pkg.sv ====
// Types shared by the host bus DMA block.
// Assumes hbd_regs.svh holds the numeric constants.
package hbd_pkg;
  typedef enum logic [1:0] {
    HBD_IDLE = 2'h0,
    HBD_REQ = 2'h1,
    HBD_XFER = 2'h3,
    HBD_GAP = 2'h2
  } hbd_state_e;
  // Transfer size code: byte, word, longword.
  typedef enum logic [1:0] {
    HBD_SZ_BYTE = 2'h0,
    HBD_SZ_WORD = 2'h1,
    HBD_SZ_LONG = 2'h2
  } hbd_size_e;
  typedef struct packed {
    hbd_state_e st;
    logic busReq;
    logic strobe;
    logic cache_burst_request;
    logic cacheTen;
    logic [4:0] limit;
    logic [4:0] beats;
    logic [3:0] gap;
    logic [31:0] addr;
    logic [23:0] rem;
    logic [31:0] mAddr;
    hbd_size_e mSize;
    logic [3:0] mBe;
    logic write;
    logic busy;
    logic done;
    logic err;
    logic inReady;
    logic [1:0][31:0] bufData;
    logic [1:0][3:0] bufLane;
    logic [1:0] bufCnt;
    logic [1:0] sPh;
    logic sAct;
    logic ready;
    logic [31:0] rdata;
    logic termOut;
    logic termOe;
    logic [3:0][7:0] regs;
    logic [7:0] status1;
    logic [7:0] status2;
  } hbd_state_s;
endpackage

// ==== verif/hbd_host_bus_model.sv ====
// Host bus model: the arbiter and a memory that answer the block's master beats.
// Assumes beats are acknowledged on transferAckN in both bus modes.
`timescale 1ns/1ps
`default_nettype none
module hbd_host_bus_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control from the testbench
  input wire logic busModeSync,
  input wire logic armRetry,
  input wire logic [7:0] retryAfter,
  input wire logic [2:0] ackDelay,
  // Master side of the block
  input wire logic busRequest,
  input wire logic masterStrobe,
  input wire logic [31:0] masterAddr,
  output logic busGrant,
  output logic [31:0] masterRdata,
  output logic transferAckN,
  output logic transferErrorAckN,
  output logic haltN,
  output logic busFaultN
);
  logic [2:0] waitCnt;
  logic [7:0] left;
  logic armed;
  logic resp;
  logic [7:0] base;
  assign base = {masterAddr[7:2], 2'h0};
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busGrant <= 1'b0;
      masterRdata <= 32'h0;
      {transferAckN, transferErrorAckN, haltN, busFaultN} <= 4'hF;
      {waitCnt, left, armed, resp} <= '0;
    end else begin
      busGrant <= busRequest;
      {transferAckN, transferErrorAckN, haltN, busFaultN} <= 4'hF;
      // Released data lines flip every cycle so stale data is never taken for a reply.
      masterRdata <= ~masterRdata;
      if (armRetry) begin
        armed <= 1'b1;
        left <= retryAfter;
      end
      if (resp || !masterStrobe) begin
        resp <= 1'b0;
        waitCnt <= 3'h0;
      end else if (waitCnt != ackDelay) begin
        waitCnt <= waitCnt + 3'h1;
      end else begin
        resp <= 1'b1;
        if (armed && left == 8'h0) begin
          armed <= 1'b0;
          if (busModeSync)
            {transferAckN, transferErrorAckN} <= 2'h0;
          else
            {haltN, busFaultN} <= 2'h0;
        end else begin
          transferAckN <= 1'b0;
          masterRdata <= {base + 8'h3, base + 8'h2, base + 8'h1, base};
          if (armed)
            left <= left - 8'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/hbd_dma_interface_tb_top.sv ====
// Testbench of the host bus DMA block: slave register cycles, status bits, DMA runs.
// Assumes the design files and the host bus model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module hbd_dma_interface_tb_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic bigEndian, busModeSync, internalAckEnable, dmaStart, dmaToMem, cacheMode;
  logic [1:0] burstSel, slaveAddr, slaveSize, masterSize, sz;
  logic [31:0] startAddr, inData, slaveWdata, masterRdata, masterAddr, masterWdata;
  logic [31:0] outData, slaveRdata, trAddr, tenAddr, rd;
  logic [23:0] byteCount;
  logic [3:0] rxFifoCount, masterByteEn, outLanes, be;
  logic dmaBusy, dmaDone, dmaError, busRequest, busGrant, masterStrobe, masterWrite;
  logic cacheBurstRequest, transferAckN, transferErrorAckN, haltN, busFaultN;
  logic inValid, inReady, outValid, outReady, chipSelectN, slaveWrite, slaveReadyOut;
  logic cycleTerminateNIn, cycleTerminateNOut, cycleTerminateOe, termDrvN, armRetry;
  logic outLatchFull, outHoldFull, inLatchFull, syncMode, track, prevReq, gapOn;
  logic [7:0] scsiStatusOne, scsiStatusTwo, retryAfter, expByte, cyc;
  logic [2:0] ackDelay;
  int trRem, tenRem, beats, gapCnt, mN, wN, err_count, samples_checked;

  hbd_dma_interface #(.COUNT_W(24)) i_dut (
    .clk_sys, .nrst, .bigEndian, .busModeSync, .internalAckEnable, .dmaStart, .dmaToMem,
    .cacheMode, .burstSel, .startAddr, .byteCount, .dmaBusy, .dmaDone, .dmaError,
    .busRequest, .busGrant, .masterStrobe, .masterWrite, .masterAddr, .masterSize,
    .masterByteEn, .masterWdata, .masterRdata, .cacheBurstRequest, .transferAckN,
    .transferErrorAckN, .haltN, .busFaultN, .inData, .inValid, .inReady, .outData,
    .outLanes, .outValid, .outReady, .chipSelectN, .slaveWrite, .slaveAddr, .slaveSize,
    .slaveWdata, .slaveRdata, .slaveReadyOut, .cycleTerminateNIn, .cycleTerminateNOut,
    .cycleTerminateOe, .outLatchFull, .outHoldFull, .inLatchFull, .syncMode,
    .rxFifoCount, .scsiStatusOne, .scsiStatusTwo);
  hbd_host_bus_model i_host (
    .clk_sys, .nrst, .busModeSync, .armRetry, .retryAfter, .ackDelay, .busRequest,
    .masterStrobe, .masterAddr, .busGrant, .masterRdata, .transferAckN,
    .transferErrorAckN, .haltN, .busFaultN);

  // The termination line has a pull-up, so it idles high when nobody drives it.
  assign cycleTerminateNIn = cycleTerminateOe ? cycleTerminateNOut : termDrvN;
  always #12.5 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic slv(input logic wr, input logic [1:0] a, input logic [1:0] s,
      input logic [31:0] wd, output logic [31:0] data);
    int n;
    @(posedge clk_sys);
    {chipSelectN, slaveWrite, slaveAddr, slaveSize, slaveWdata} <= {1'b0, wr, a, s, wd};
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (slaveReadyOut !== 1'b1 && n < 20);
    check(32'(slaveReadyOut), 32'h1);
    data = slaveRdata;
    check(32'(cycleTerminateOe), 32'(internalAckEnable));
    if (internalAckEnable !== 1'b1) begin
      @(posedge clk_sys);
      termDrvN <= 1'b0;
      @(negedge clk_sys);
      check(32'(slaveReadyOut), 32'h1);
    end
    @(posedge clk_sys);
    {chipSelectN, termDrvN} <= 2'h3;
    @(negedge clk_sys);
    check(32'(slaveReadyOut), 32'h0);
  endtask

  task automatic dmaRun(input logic toMem, input logic cache, input logic [1:0] bs,
      input logic [31:0] addr, input int cnt, input logic [7:0] rAfter, input logic expErr);
    int n;
    @(posedge clk_sys);
    {dmaToMem, cacheMode, burstSel, startAddr, byteCount} <= {toMem, cache, bs, addr, 24'(cnt)};
    {dmaStart, retryAfter, armRetry} <= {1'b1, rAfter, rAfter != 8'hFF};
    {trAddr, trRem, expByte, gapOn, track} = {addr, cnt, addr[7:0], 1'b0, !expErr};
    @(posedge clk_sys);
    {dmaStart, armRetry} <= 2'h0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (dmaDone !== 1'b1 && n < 3000);
    check(32'(dmaDone), 32'h1);
    check(32'(dmaBusy), 32'h0);
    check(32'(dmaError), 32'(expErr));
    if (!expErr)
      check(trRem, 0);
    n = 0;
    while (outValid !== 1'b0 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus monitor, FIFO-side source and sink. Expected sizes follow the alignment rules.
  always @(posedge clk_sys) begin
    cyc <= cyc + 8'h1;
    outReady <= cyc[3];
    if (inReady)
      inData <= inData + 32'h1;
    if (track && outValid && outReady)
      for (int l = 0; l < 4; l++)
        if (outLanes[l]) begin
          check(32'(outData[8*l +: 8]), 32'(expByte));
          expByte++;
        end
    if (track && masterStrobe && !transferAckN && transferErrorAckN) begin
      sz = (trAddr[0] || trRem == 1) ? 2'h0 : (trAddr[1] || trRem < 4) ? 2'h1 : 2'h2;
      mN = 1 << sz;
      be = (mN == 1) ? 4'h1 : (mN == 2) ? 4'h3 : 4'hF;
      be = be << trAddr[1:0];
      check(masterAddr, trAddr);
      check(32'(masterSize), 32'(sz));
      check(32'(masterByteEn), 32'(be));
      check(32'(masterWrite), 32'(dmaToMem));
      if (dmaToMem) begin
        // FIFO words are consumed in order, one per acknowledged write beat.
        check(masterWdata, 32'(wN));
        wN++;
      end
      check(32'(cacheBurstRequest),
            32'(cacheMode && tenRem >= 32 && tenAddr[3:0] == 4'h0));
      trAddr = trAddr + mN;
      trRem -= mN;
      beats++;
    end
    if (busRequest && !prevReq) begin
      if (track && gapOn)
        check(32'(gapCnt >= 5 && gapCnt <= 8), 32'h1);
      {tenAddr, tenRem, beats} = {trAddr, tenRem + 0 == 0 ? trRem : trRem, 32'h0};
    end
    if (!busRequest && prevReq && track) begin
      mN = cacheMode ? (tenRem < 32 ? beats : (tenAddr[3:0] == 0 ? 4 : 1)) : (1 << burstSel);
      if (!cacheMode && trRem == 0 && beats <= mN)
        mN = beats;
      check(beats, mN);
    end
    gapCnt = (!busRequest && prevReq) ? 1 : gapCnt + 1;
    gapOn = gapOn | (!busRequest && prevReq);
    prevReq = busRequest;
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    test_done;
  end

  initial begin
    {bigEndian, busModeSync, internalAckEnable, dmaStart, dmaToMem, cacheMode} = '0;
    {burstSel, startAddr, byteCount, inData, armRetry, retryAfter} = '0;
    inValid = 1'b1;
    {chipSelectN, slaveWrite, slaveAddr, slaveSize, slaveWdata, termDrvN} = {1'b1, 37'h0, 1'b1};
    {outLatchFull, outHoldFull, inLatchFull, syncMode, rxFifoCount, outReady} = '0;
    {cyc, ackDelay, track, prevReq, gapOn, tenRem, trRem, wN, err_count, samples_checked} = '0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    slv(1'b0, 2'h0, 2'h2, 32'h0, rd);
    check(rd, 32'h0);
    slv(1'b1, 2'h0, 2'h0, 32'h000000A5, rd);
    slv(1'b1, 2'h2, 2'h1, 32'hBEEF0000, rd);
    slv(1'b0, 2'h0, 2'h2, 32'h0, rd);
    check(rd, 32'hBEEF00A5);
    @(posedge clk_sys);
    {bigEndian, internalAckEnable} <= 2'h3;
    slv(1'b1, 2'h3, 2'h0, 32'h0000003C, rd);
    slv(1'b1, 2'h0, 2'h1, 32'h12340000, rd);
    slv(1'b1, 2'h2, 2'h0, 32'h00005600, rd);
    slv(1'b0, 2'h0, 2'h2, 32'h0, rd);
    check(rd, 32'h1234563C);
    @(posedge clk_sys);
    {outLatchFull, outHoldFull, inLatchFull, rxFifoCount} <= {3'h7, 4'h9};
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      {syncMode, dmaToMem} <= {m[0], m[1]};
      repeat (3) @(negedge clk_sys);
      check(32'(scsiStatusOne & 8'hE0), 32'({m[1] & ~m[0], 1'b1, m[0] & ~m[1], 5'h0}));
      check(32'(scsiStatusTwo & 8'hF0), (m == 3) ? 32'h90 : 32'h0);
    end
    @(posedge clk_sys);
    {outLatchFull, outHoldFull, inLatchFull, syncMode, dmaToMem} <= 5'h08;
    repeat (3) @(negedge clk_sys);
    check(32'(scsiStatusOne & 8'hE0), 32'h0);
    @(posedge clk_sys);
    {busModeSync, bigEndian, syncMode} <= 3'h4;
    // Four single acks, then a retry on the last single alignment beat, which must be honoured.
    dmaRun(1'b0, 1'b1, 2'h0, 32'h1001, 86, 8'h04, 1'b0);
    @(posedge clk_sys);
    {busModeSync, ackDelay} <= {1'b0, 3'h3};
    dmaRun(1'b1, 1'b0, 2'h2, 32'h2002, 23, 8'h02, 1'b0);
    @(posedge clk_sys);
    ackDelay <= 3'h1;
    for (int b = 0; b < 4; b++)
      dmaRun(1'b0, 1'b0, 2'(b), 32'h3001, 10, 8'hFF, 1'b0);
    @(posedge clk_sys);
    busModeSync <= 1'b1;
    // Line-aligned start, so bursting begins at once; a retry on beat three is fatal.
    dmaRun(1'b0, 1'b1, 2'h0, 32'h4000, 64, 8'h02, 1'b1);
    test_done;
  end
endmodule
`default_nettype wire
